/* File: verilog/smp_port.sv */
// Overview of operation
// - As master, writing the data register starts SCK and shifts eight bits.
// - After one master byte the clock stops and the done flag sets.
// - Done flag with interrupt enable set raises the interrupt request.
// - Master never drives slave select itself; software owns that line.
// - Data goes master to slave on MOSI, back on MISO, simultaneously.
// - Completed bytes queue in a two-entry receive buffer; a slave byte arriving while it is full is lost.
// - Deselected slave stays idle with MISO released.
// - Deselected slave accepts data writes but shifts nothing until selected.
// - Slave sets the done flag once a full byte has shifted.
// - Transmit path single buffered; no new byte until shifting ends.
// - Enabled port drives a pin only where the user direction marks it as output and the master or slave role allows it.
// - Bit order selectable, least or most significant bit first.
// - Master offers seven SCK rates including half the system clock.
// - A write collision flag protects a running transfer.
// - A completed transfer can wake the processor from idle sleep.
// - Select going high resets slave shift logic and drops partial bits.
// - Select input low in master role forces slave role and sets done.
// - Writing data during a transfer sets the write collision flag.
// - Polarity sets SCK idle level; phase picks sampling edge.
module smp_port
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire smp_pkg::smp_ctrl_t ctrl,
  input wire smp_pkg::smp_dir_t user_dir,
  input wire logic ss_user_level,
  input wire logic role_wr,
  input wire logic role_wdata,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic state_rd,
  input wire logic irq_ack,
  output smp_pkg::smp_status_t status,
  output logic irq,
  output logic idle_wake,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n
);
  import smp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } smp_state_t;

  function automatic logic [7:0] shift_in(logic [7:0] v, logic b,
                                          logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  function automatic logic head(logic [7:0] v, logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  function automatic logic [6:0] half_period(smp_ctrl_t c);
    return 7'(SMP_SCK_DIV[{c.double_rate, c.rate}] / 2);
  endfunction

  logic [3:0] pin_f;
  logic ss_f;
  logic sck_f;
  logic in_bit;
  smp_state_t state_q, state_d;
  logic role_q, role_d;
  logic done_q, done_d;
  logic write_collision_flag_q, write_collision_flag_d;
  logic arm_q, arm_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic [3:0] edge_q, edge_d;
  logic [6:0] div_q, div_d;
  logic sck_q, sck_d;
  logic sck_prev_q;
  logic out_q, out_d;
  logic master, slave_act, mode_fault;
  logic m_tick, s_edge, sck_edge, lead, sample, setup;
  logic busy, wr_take, collide, data_acc;
  logic m_done, s_done, byte_done, fifo_in_ready;
  logic [7:0] rx_byte, rx_word;

  smp_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din({ss_n_i, sck_i, miso_i, mosi_i}),
    .dout(pin_f)
  );

  assign ss_f = pin_f[3];
  assign sck_f = pin_f[2];
  // Master MISO returns on our own SCK, so it is taken without the filter lag
  assign in_bit = master ? miso_i : pin_f[0];

  assign master = ctrl.port_en & role_q;
  assign slave_act = ctrl.port_en & ~role_q & ~ss_f;
  assign mode_fault = master & ~user_dir.ss & ~ss_f;

  assign m_tick = (state_q == ST_RUN) & (div_q == half_period(ctrl) - 7'h01);
  assign s_edge = slave_act & (sck_f != sck_prev_q);
  assign sck_edge = master ? m_tick : s_edge;
  assign lead = master ? (sck_q == ctrl.cpol) : (sck_f != ctrl.cpol);
  // Sample and setup sit on opposite edges; first edge never shifts
  assign sample = sck_edge & (lead ^ ctrl.cpha);
  assign setup = sck_edge & ~(lead ^ ctrl.cpha) & (edge_q != SMP_EDGE_FIRST);

  // A deselected slave is never busy, so it takes new data
  assign busy = (state_q != ST_IDLE) | (slave_act & (edge_q != SMP_EDGE_FIRST));
  assign wr_ready = ~busy;
  assign wr_take = wr_valid & ~busy;
  assign collide = wr_valid & busy;
  assign data_acc = wr_valid | (rx_valid & rx_ready);

  assign m_done = master & m_tick & (edge_q == SMP_EDGE_LAST);
  assign s_done = sample & ~master & (edge_q[3:1] == SMP_SAMPLE_LAST);
  assign byte_done = m_done | s_done;
  assign rx_byte = shift_in(rx_q, in_bit, ctrl.lsb_first);
  assign rx_word = sample ? rx_byte : rx_q;

  // Completed bytes queue for software; a full slave queue drops the byte
  smp_fifo2 #(
    .WIDTH(SMP_BYTE_BITS),
    .DEPTH(2)
  ) u_rxbuf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(byte_done),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (wr_take & master)
        begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Hold off the clock while the receive queue is full
        if (fifo_in_ready)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (m_done)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (mode_fault | ~master)
    begin
      state_d = ST_IDLE;
    end

    div_d = (state_q == ST_RUN && !m_tick) ? div_q + 7'h01 : SMP_DIV_RST;

    if (state_q == ST_RUN)
    begin
      sck_d = m_tick ? ~sck_q : sck_q;
    end
    else
    begin
      sck_d = ctrl.cpol;
    end

    edge_d = sck_edge ? edge_q + 4'h1 : edge_q;
    if ((master && state_q != ST_RUN) || (!master && !slave_act))
    begin
      edge_d = SMP_EDGE_FIRST;
    end

    tx_d = tx_q;
    if (wr_take)
    begin
      tx_d = wr_data;
    end
    else if (setup)
    begin
      tx_d = shift_in(tx_q, 1'b0, ctrl.lsb_first);
    end

    rx_d = sample ? rx_byte : rx_q;
    if (!master && !slave_act)
    begin
      rx_d = SMP_BYTE_RST;
    end

    out_d = head(tx_d, ctrl.lsb_first);

    role_d = role_wr ? role_wdata : role_q;
    if (mode_fault)
    begin
      role_d = 1'b0;
    end

    // Clear first, so an event in the same cycle still sets
    done_d = done_q;
    write_collision_flag_d = write_collision_flag_q;
    if ((arm_q & data_acc) | irq_ack)
    begin
      done_d = 1'b0;
      write_collision_flag_d = 1'b0;
    end
    if (byte_done | mode_fault)
    begin
      done_d = 1'b1;
    end
    if (collide)
    begin
      write_collision_flag_d = 1'b1;
    end

    arm_d = arm_q;
    if (state_rd & (done_q | write_collision_flag_q))
    begin
      arm_d = 1'b1;
    end
    else if (data_acc | irq_ack)
    begin
      arm_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      role_q <= SMP_ROLE_RST;
      done_q <= SMP_FLAG_RST;
      write_collision_flag_q <= SMP_FLAG_RST;
      arm_q <= SMP_FLAG_RST;
      tx_q <= SMP_BYTE_RST;
      rx_q <= SMP_BYTE_RST;
      edge_q <= SMP_EDGE_FIRST;
      div_q <= SMP_DIV_RST;
      sck_q <= 1'b0;
      sck_prev_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      role_q <= role_d;
      done_q <= done_d;
      write_collision_flag_q <= write_collision_flag_d;
      arm_q <= arm_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      edge_q <= edge_d;
      div_q <= div_d;
      sck_q <= sck_d;
      sck_prev_q <= sck_f;
      out_q <= out_d;
    end
  end

  assign status = '{transfer_done_flag: done_q,
                    write_collision_flag: write_collision_flag_q,
                    host_role_select: role_q};
  assign irq = done_q & ctrl.irq_en;
  assign idle_wake = irq;

  assign sck_o = sck_q;
  assign mosi_o = out_q;
  assign miso_o = out_q;
  assign ss_n_o = ss_user_level;
  assign mosi_oe_n = ~(master & user_dir.mosi);
  assign sck_oe_n = ~(master & user_dir.sck);
  assign ss_n_oe_n = ~(master & user_dir.ss);
  assign miso_oe_n = ~(slave_act & user_dir.miso);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_start;
    master && state_q == ST_IDLE && wr_valid && !mode_fault
      |=> state_q == ST_WAIT && tx_q == $past(wr_data);
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_master_done;
    m_done && !mode_fault |=> done_q && state_q == ST_IDLE;
  endproperty
  a_master_done: assert property (p_master_done) else $error("no stop");

  property p_irq;
    byte_done && ctrl.irq_en ##1 ctrl.irq_en |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing interrupt");

  property p_select_free;
    master && user_dir.ss |-> !ss_n_oe_n && ss_n_o == ss_user_level;
  endproperty
  a_select_free: assert property (p_select_free) else $error("select");

  property p_miso_idle;
    !role_q && ss_f |-> miso_oe_n;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven");

  property p_slave_done;
    s_done |=> done_q;
  endproperty
  a_slave_done: assert property (p_slave_done) else $error("slave flag");

  property p_collide;
    wr_valid && busy && !setup |=> write_collision_flag_q && tx_q == $past(tx_q);
  endproperty
  a_collide: assert property (p_collide) else $error("no collision");

  property p_desel;
    ctrl.port_en && !role_q && ss_f |=> edge_q == 4'h0 && rx_q == 8'h00;
  endproperty
  a_desel: assert property (p_desel) else $error("slave not reset");

  property p_fault;
    mode_fault |=> !role_q && done_q && state_q == ST_IDLE;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault");

  property p_sck_idle;
    master && state_q != ST_RUN |=> sck_o == $past(ctrl.cpol);
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck idle");

  property p_clear;
    arm_q && data_acc && !byte_done && !collide && !mode_fault
      |=> !done_q && !write_collision_flag_q;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept");

  property p_rx_keep;
    byte_done && fifo_in_ready |=> rx_valid;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("byte lost");

endmodule

/* File: common/smp_pkg.sv */
package smp_pkg;

  localparam int SMP_BYTE_BITS = 8;
  localparam logic [3:0] SMP_EDGE_FIRST = 4'h0;
  localparam logic [3:0] SMP_EDGE_LAST = 4'hf;
  localparam logic [2:0] SMP_SAMPLE_LAST = 3'h7;

  // Master SCK divisors, indexed by {double_rate, rate}
  localparam int SMP_SCK_DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

  localparam logic SMP_ROLE_RST = 1'b0;
  localparam logic SMP_FLAG_RST = 1'b0;
  localparam logic [7:0] SMP_BYTE_RST = 8'h00;
  localparam logic [6:0] SMP_DIV_RST = 7'h00;
  // Pin order {ss_n, sck, miso, mosi}; select reads idle-high
  localparam logic [3:0] SMP_PIN_RST = 4'h8;

  typedef struct packed {
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic cpol;
    logic cpha;
    logic [1:0] rate;
    logic double_rate;
  } smp_ctrl_t;

  // One means the user configured the pin as an output
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } smp_dir_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic host_role_select;
  } smp_status_t;

endpackage

/* File: verilog/smp_sync.sv */
module smp_sync
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] din,
  output logic [3:0] dout
);
  import smp_pkg::*;

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] filt_q;
  logic [3:0] filt_d;

  // A level is taken once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= SMP_PIN_RST;
      s2_q <= SMP_PIN_RST;
      s3_q <= SMP_PIN_RST;
      filt_q <= SMP_PIN_RST;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // The agreed level passes on at once to save a cycle of link latency
  assign dout = filt_d;

endmodule

/* File: verilog/smp_fifo2.sv */
module smp_fifo2
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import smp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] wp_d;
  logic [AW-1:0] rp_q;
  logic [AW-1:0] rp_d;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push)
    begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
    end
    if (pop)
    begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: tb/smp_peer.sv */
module smp_peer
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  output logic p_sck,
  output logic p_mosi,
  output logic p_miso,
  output logic p_ss_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic host = 1'b0;
  logic lead = 1'b1;
  logic o;
  logic din;
  initial p_sck = 1'b0;
  initial p_ss_n = 1'b1;
  assign o = lsb ? sh[0] : sh[7];
  // Released data line shows the inverse of the next bit to send
  assign p_miso = ss_n ? ~o : o;
  assign p_mosi = p_miso;
  assign din = host ? miso : mosi;
  always @(negedge ss_n) lead = 1'b1;
  always @(sck)
    if (!ss_n)
    begin
      if (sck == !(cpol ^ cpha))
        rx = lsb ? {din, rx[7:1]} : {rx[6:0], din};
      else if (!(lead && cpha))
        sh = lsb ? sh >> 1 : sh << 1;
      lead = 1'b0;
    end
  // Acts as the far master; SCK period 400 ns, idle between frames
  task automatic xfer(input logic [7:0] b, input int n);
    host = 1'b1;
    sh = b;
    p_sck = cpol;
    p_ss_n = 1'b0;
    #400;
    repeat (n)
    begin
      #200 p_sck = ~p_sck;
    end
    #400 p_ss_n = 1'b1;
    host = 1'b0;
    #200;
  endtask
endmodule

/* File: tb/smp_port_test.sv */
module smp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smp_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  smp_ctrl_t ctrl = '0;
  smp_dir_t user_dir = '0;
  logic ss_user_level = 1'b1;
  logic role_wr = 1'b0;
  logic role_wdata = 1'b0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rx_ready = 1'b0;
  logic state_rd = 1'b0;
  logic irq_ack = 1'b0;
  logic wr_ready, rx_valid, irq, idle_wake;
  logic [7:0] rx_data;
  smp_status_t status;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic ss_n_o, ss_n_oe_n, p_sck, p_mosi, p_miso, p_ss_n;
  wire sck_w = sck_oe_n ? p_sck : sck_o;
  wire mosi_w = mosi_oe_n ? p_mosi : mosi_o;
  wire miso_w = miso_oe_n ? p_miso : miso_o;
  wire ss_w = ss_n_oe_n ? p_ss_n : ss_n_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  always #25 sys_clk = ~sys_clk;

  smp_port uut (.sys_clk, .rstn, .ctrl, .user_dir, .ss_user_level,
    .role_wr, .role_wdata, .wr_valid, .wr_data, .wr_ready, .rx_valid,
    .rx_data, .rx_ready, .state_rd, .irq_ack, .status, .irq, .idle_wake,
    .sck_i(sck_w), .sck_o, .sck_oe_n, .mosi_i(mosi_w), .mosi_o,
    .mosi_oe_n, .miso_i(miso_w), .miso_o, .miso_oe_n, .ss_n_i(ss_w),
    .ss_n_o, .ss_n_oe_n);

  smp_peer peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .ss_n(ss_w),
    .cpol(ctrl.cpol), .cpha(ctrl.cpha), .lsb(ctrl.lsb_first), .p_sck,
    .p_mosi, .p_miso, .p_ss_n);

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic put(input logic [7:0] b);
    @(posedge sys_clk);
    wr_valid <= 1'b1;
    wr_data <= b;
    @(posedge sys_clk);
    wr_valid <= 1'b0;
  endtask

  // Raise select, read status, then pop the receive buffer
  task automatic take(input logic [7:0] e);
    @(negedge sys_clk);
    check(rx_valid, 1'b1);
    check(rx_data, e);
    @(posedge sys_clk);
    ss_user_level <= 1'b1;
    state_rd <= 1'b1;
    @(posedge sys_clk);
    state_rd <= 1'b0;
    rx_ready <= 1'b1;
    @(posedge sys_clk);
    rx_ready <= 1'b0;
    @(negedge sys_clk);
    check(status[2:1], 2'b00);
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (status.transfer_done_flag !== 1'b1 && n < 4000)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic t_reset;
    @(negedge sys_clk);
    check(status, 3'h0);
    check({sck_oe_n, mosi_oe_n, miso_oe_n, ss_n_oe_n}, 4'hf);
    check({irq, wr_ready, rx_valid}, 3'h2);
  endtask

  task automatic t_master;
    int n;
    logic [7:0] tx;
    logic [7:0] px;
    @(posedge sys_clk);
    user_dir <= '{mosi: 1'b1, miso: 1'b1, sck: 1'b1, ss: 1'b1};
    role_wr <= 1'b1;
    role_wdata <= 1'b1;
    @(posedge sys_clk);
    role_wr <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      tx = 8'hc5 + 8'(i * 37);
      px = 8'h2e ^ 8'(i * 83);
      @(posedge sys_clk);
      ctrl <= {i[1], 1'b1, i[2] ^ i[0], i[0], i[1], i[1:0], i[2]};
      peer.sh = px;
      tick(2);
      ss_user_level <= 1'b0;
      put(tx);
      wait_done(n);
      check(n >= 8 * SMP_SCK_DIV[i] - 2 && n <= 8 * SMP_SCK_DIV[i] + 8, 1);
      @(negedge sys_clk);
      check(peer.rx, tx);
      check(status, 3'h5);
      check({irq, idle_wake}, {2{i[1]}});
      check(sck_o, i[0]);
      check({sck_oe_n, mosi_oe_n, miso_oe_n, ss_n_oe_n, ss_n_o}, 5'h04);
      take(px);
    end
    peer.sh = 8'h00;
    @(posedge sys_clk);
    ss_user_level <= 1'b0;
    put(8'h81);
    put(8'h42);
    @(negedge sys_clk);
    check({wr_ready, status.write_collision_flag}, 2'b01);
    wait_done(n);
    @(negedge sys_clk);
    check(peer.rx, 8'h81);
    take(8'h00);
    check(ss_n_o, 1'b1);
  endtask

  task automatic t_fault;
    @(posedge sys_clk);
    user_dir <= '{mosi: 1'b1, miso: 1'b0, sck: 1'b1, ss: 1'b0};
    ctrl <= 8'h40;
    tick(2);
    peer.p_ss_n = 1'b0;
    tick(8);
    @(negedge sys_clk);
    check(status, 3'h4);
    check({sck_oe_n, mosi_oe_n, irq}, 3'h6);
    peer.p_ss_n = 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    @(negedge sys_clk);
    check(status, 3'h0);
  endtask

  task automatic t_slave;
    @(posedge sys_clk);
    user_dir <= '{mosi: 1'b0, miso: 1'b1, sck: 1'b0, ss: 1'b0};
    put(8'h96);
    tick(20);
    @(negedge sys_clk);
    check({wr_ready, miso_oe_n, status.transfer_done_flag}, 3'h6);
    peer.xfer(8'ha1, 16);
    tick(4);
    @(negedge sys_clk);
    check(status.transfer_done_flag, 1'b1);
    check(peer.rx, 8'h96);
    check({sck_oe_n, mosi_oe_n, ss_n_oe_n, miso_oe_n}, 4'hf);
    peer.xfer(8'h77, 6);
    put(8'h3c);
    take(8'ha1);
    peer.xfer(8'hb2, 16);
    check(peer.rx, 8'h3c);
    peer.xfer(8'hc3, 16);
    peer.xfer(8'hd4, 16);
    tick(8);
    take(8'hb2);
    take(8'hc3);
    check(rx_valid, 1'b0);
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(4);
    t_reset;
    t_master;
    t_fault;
    t_slave;
    conclude;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude;
    end
  end
endmodule
